// ---- design/rioc_pkg.sv ----
/*
 * Shared constants for the remote I/O conditioner: APB register map,
 * field layouts, input mode codes, output channel codes and timing.
 * Assumes a 125 MHz system clock and 32-bit APB data.
 */
package rioc_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int RIOC_NUM_IN = 10;
    localparam int RIOC_NUM_OUT = 16;
    localparam int RIOC_MODE_W = 4;
    localparam int RIOC_CHAN_W = 5;
    localparam int RIOC_SRC_W = 16;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] RIOC_CTRL_OFS = 12'h000;
    localparam logic [11:0] RIOC_PIN_OFS = 12'h004;
    localparam logic [11:0] RIOC_FUNC_OFS = 12'h008;
    localparam logic [11:0] RIOC_PULSE_OFS = 12'h00c;
    localparam logic [11:0] RIOC_POWER_OFS = 12'h010;
    localparam logic [11:0] RIOC_SRC_OFS = 12'h014;
    localparam logic [11:0] RIOC_OUTPIN_OFS = 12'h018;
    localparam logic [11:0] RIOC_EXEMPT_OFS = 12'h01c;
    localparam logic [11:0] RIOC_IMODE_OFS = 12'h040;
    localparam logic [11:0] RIOC_OCFG_OFS = 12'h080;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int RIOC_CTRL_REN_BIT = 0;
    localparam int RIOC_OCFG_POL_BIT = 8;
    localparam int RIOC_POW_INC_BIT = 0;
    localparam int RIOC_POW_DEC_BIT = 1;
    localparam int RIOC_POW_STEP_BIT = 2;
    localparam int RIOC_POW_IDX_LSB = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [RIOC_MODE_W-1:0] RIOC_IMODE_RST = 4'h0;
    localparam logic [RIOC_CHAN_W-1:0] RIOC_CHAN_RST = 5'h00;
    // ------------------------------------------------------------
    // input interpretation modes
    // ------------------------------------------------------------
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_OFF = 4'h0;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_RISE_ON = 4'h1;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_FALL_ON = 4'h2;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_RISE_OFF = 4'h3;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_FALL_OFF = 4'h4;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_FALL_TOG = 4'h5;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_RISE_TOG = 4'h6;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_RISE_ONOFF = 4'h7;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_FALL_ONOFF = 4'h8;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_HI_INC = 4'h9;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_LO_INC = 4'ha;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_HI_DEC = 4'hb;
    localparam logic [RIOC_MODE_W-1:0] RIOC_M_LO_DEC = 4'hc;
    // ------------------------------------------------------------
    // output channels: 0 none, 1 remote enable, 2..17 source bus
    // ------------------------------------------------------------
    localparam logic [RIOC_CHAN_W-1:0] RIOC_CH_NONE = 5'h00;
    localparam logic [RIOC_CHAN_W-1:0] RIOC_CH_REMOTE = 5'h01;
    localparam logic [RIOC_CHAN_W-1:0] RIOC_CH_SRC0 = 5'h02;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int RIOC_CLK_HZ = 125000000;
    localparam int RIOC_REPEAT_MS = 500;
    localparam int RIOC_REPEAT_CYC = RIOC_CLK_HZ / 1000 * RIOC_REPEAT_MS;
endpackage

// ---- design/rioc_top.sv ----
/*
 * Remote I/O conditioner: ten conditioned remote inputs driving function
 * states, pulses and power step requests, and sixteen open-collector
 * remote outputs mapped to status sources. Registers over APB.
 * Assumes input pins are synchronous in name only (two-stage sync inside),
 * and that status/alarm sources arrive as a level bus on clk_sys.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - ten remote inputs, each with its own interpretation mode
// - rising-on: rising edge activates, or pulses a reset
// - falling-on: falling edge activates, or pulses a reset
// - rising-off: rising edge deactivates the function
// - falling-off: falling edge deactivates the function
// - falling-toggle: each falling edge flips the function state
// - rising-toggle: each rising edge flips the function state
// - rise-on/fall-off: function follows the input level
// - fall-on/rise-off: function follows the inverted input level
// - high level requests increase or holds preset while present
// - low level requests increase or holds preset while present
// - high level requests power decrease while present
// - low level requests power decrease while present
// - inputs ignored unless remote enabled, except exempt ones
// - sixteen outputs, each selecting one source or none
// - unassigned output monitors nothing
// - remote-enable output low when enabled, inactive when disabled
// - active preset output low, other preset outputs released
// - active exciter output low, other exciter output released
// - alarm-mapped output active while the alarm is present
// - audio-activity output low while its selected path is active
// - each output has a polarity choosing low meaning true or false
// - held power input repeats a 1% step every half second
// - several power inputs active: lowest index wins
module rioc_top
    import rioc_pkg::*;
#(
    parameter int REPEAT_CYC = RIOC_REPEAT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [RIOC_NUM_IN-1:0] remote_in,
    input wire logic [RIOC_SRC_W-1:0] status_src,
    output logic [RIOC_NUM_IN-1:0] func_active,
    output logic [RIOC_NUM_IN-1:0] func_pulse,
    output logic power_inc,
    output logic power_dec,
    output logic power_step,
    output logic [RIOC_NUM_OUT-1:0] remote_out_o,
    output logic [RIOC_NUM_OUT-1:0] remote_out_oe
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RIOC_PW_IDLE = 2'b01,
        RIOC_PW_HOLD = 2'b10
    } rioc_pw_type;

    logic [RIOC_NUM_IN-1:0] sync1_r;
    logic [RIOC_NUM_IN-1:0] sync2_r;
    logic [RIOC_NUM_IN-1:0] prev_r;
    logic [RIOC_NUM_IN-1:0] exempt_r;
    logic [RIOC_NUM_IN-1:0] func_r;
    logic [RIOC_NUM_IN-1:0] func_nxt;
    logic [RIOC_NUM_IN-1:0] pulse_r;
    logic [RIOC_NUM_IN-1:0] pulse_nxt;
    logic [RIOC_NUM_IN-1:0] inc_req;
    logic [RIOC_NUM_IN-1:0] dec_req;
    logic [RIOC_MODE_W-1:0] imode_r [RIOC_NUM_IN];
    logic [RIOC_CHAN_W-1:0] chan_r [RIOC_NUM_OUT];
    logic [RIOC_NUM_OUT-1:0] pol_r;
    logic [RIOC_NUM_OUT-1:0] drive_low;
    logic ren_r;
    logic [31:0] rd_nxt;
    logic wr_en;
    logic rd_en;
    rioc_pw_type pw_state_r;
    logic [31:0] pw_cnt_r;
    logic pw_any;
    logic pw_is_inc;
    logic [3:0] pw_idx;
    logic pw_inc_r;
    logic pw_dec_r;
    logic pw_step_r;
    logic [3:0] pw_idx_r;

    // true when the address selects entry idx of an array block
    function automatic logic rioc_hit(input logic [11:0] a,
                                      input logic [11:0] base,
                                      input int idx);
        rioc_hit = (a == base + 12'(idx * 4));
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite; // setup cycle of a read
    assign pready = 1'b1;

    // read mux; unmapped addresses read zero with an error
    always_comb begin
        rd_nxt = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == RIOC_CTRL_OFS) begin
            rd_nxt[RIOC_CTRL_REN_BIT] = ren_r;
        end else if (paddr == RIOC_PIN_OFS) begin
            rd_nxt[RIOC_NUM_IN-1:0] = sync2_r;
        end else if (paddr == RIOC_FUNC_OFS) begin
            rd_nxt[RIOC_NUM_IN-1:0] = func_r;
        end else if (paddr == RIOC_PULSE_OFS) begin
            rd_nxt[RIOC_NUM_IN-1:0] = pulse_r;
        end else if (paddr == RIOC_POWER_OFS) begin
            rd_nxt[RIOC_POW_INC_BIT] = pw_inc_r;
            rd_nxt[RIOC_POW_DEC_BIT] = pw_dec_r;
            rd_nxt[RIOC_POW_STEP_BIT] = pw_step_r;
            rd_nxt[RIOC_POW_IDX_LSB +: 4] = pw_idx_r;
        end else if (paddr == RIOC_SRC_OFS) begin
            rd_nxt[RIOC_SRC_W-1:0] = status_src;
        end else if (paddr == RIOC_OUTPIN_OFS) begin
            rd_nxt[RIOC_NUM_OUT-1:0] = ~drive_low;
        end else if (paddr == RIOC_EXEMPT_OFS) begin
            rd_nxt[RIOC_NUM_IN-1:0] = exempt_r;
        end else begin
            pslverr = psel & penable;
            for (int i = 0; i < RIOC_NUM_IN; i++) begin
                if (rioc_hit(paddr, RIOC_IMODE_OFS, i)) begin
                    rd_nxt[RIOC_MODE_W-1:0] = imode_r[i];
                    pslverr = 1'b0;
                end
            end
            for (int j = 0; j < RIOC_NUM_OUT; j++) begin
                if (rioc_hit(paddr, RIOC_OCFG_OFS, j)) begin
                    rd_nxt[RIOC_CHAN_W-1:0] = chan_r[j];
                    rd_nxt[RIOC_OCFG_POL_BIT] = pol_r[j];
                    pslverr = 1'b0;
                end
            end
        end
    end

    // read data register, loaded in setup so it stands through access
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_nxt;
        end
    end

    // local control: remote enable and exemption mask
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ren_r <= 1'b0;
            exempt_r <= '0;
        end else if (wr_en && paddr == RIOC_CTRL_OFS) begin
            ren_r <= pwdata[RIOC_CTRL_REN_BIT];
        end else if (wr_en && paddr == RIOC_EXEMPT_OFS) begin
            exempt_r <= pwdata[RIOC_NUM_IN-1:0];
        end
    end

    // per-input mode and per-output channel/polarity storage
    generate
        for (genvar gi = 0; gi < RIOC_NUM_IN; gi++) begin : g_imode
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    imode_r[gi] <= RIOC_IMODE_RST;
                end else if (wr_en && rioc_hit(paddr, RIOC_IMODE_OFS, gi)) begin
                    imode_r[gi] <= pwdata[RIOC_MODE_W-1:0];
                end
            end
        end
        for (genvar go = 0; go < RIOC_NUM_OUT; go++) begin : g_ocfg
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    chan_r[go] <= RIOC_CHAN_RST;
                    pol_r[go] <= 1'b0;
                end else if (wr_en && rioc_hit(paddr, RIOC_OCFG_OFS, go)) begin
                    chan_r[go] <= pwdata[RIOC_CHAN_W-1:0];
                    pol_r[go] <= pwdata[RIOC_OCFG_POL_BIT];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // two-stage synchroniser, then previous-level store for edges
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= remote_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // mode decode; gated inputs leave state untouched
    always_comb begin
        func_nxt = func_r;
        pulse_nxt = '0;
        inc_req = '0;
        dec_req = '0;
        for (int i = 0; i < RIOC_NUM_IN; i++) begin
            if (ren_r || exempt_r[i]) begin
                case (imode_r[i])
                    RIOC_M_RISE_ON: begin
                        if (sync2_r[i] && !prev_r[i]) begin
                            func_nxt[i] = 1'b1;
                            pulse_nxt[i] = 1'b1;
                        end
                    end
                    RIOC_M_FALL_ON: begin
                        if (!sync2_r[i] && prev_r[i]) begin
                            func_nxt[i] = 1'b1;
                            pulse_nxt[i] = 1'b1;
                        end
                    end
                    RIOC_M_RISE_OFF: begin
                        if (sync2_r[i] && !prev_r[i]) begin
                            func_nxt[i] = 1'b0;
                        end
                    end
                    RIOC_M_FALL_OFF: begin
                        if (!sync2_r[i] && prev_r[i]) begin
                            func_nxt[i] = 1'b0;
                        end
                    end
                    RIOC_M_FALL_TOG: begin
                        if (!sync2_r[i] && prev_r[i]) begin
                            func_nxt[i] = ~func_r[i];
                        end
                    end
                    RIOC_M_RISE_TOG: begin
                        if (sync2_r[i] && !prev_r[i]) begin
                            func_nxt[i] = ~func_r[i];
                        end
                    end
                    RIOC_M_RISE_ONOFF: func_nxt[i] = sync2_r[i];
                    RIOC_M_FALL_ONOFF: func_nxt[i] = ~sync2_r[i];
                    RIOC_M_HI_INC: begin
                        inc_req[i] = sync2_r[i];
                        func_nxt[i] = sync2_r[i];
                    end
                    RIOC_M_LO_INC: begin
                        inc_req[i] = ~sync2_r[i];
                        func_nxt[i] = ~sync2_r[i];
                    end
                    RIOC_M_HI_DEC: dec_req[i] = sync2_r[i];
                    RIOC_M_LO_DEC: dec_req[i] = ~sync2_r[i];
                    default: func_nxt[i] = 1'b0;
                endcase
            end
        end
    end

    // function state and one-cycle activation pulses
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            func_r <= '0;
            pulse_r <= '0;
        end else begin
            func_r <= func_nxt;
            pulse_r <= pulse_nxt;
        end
    end
    assign func_active = func_r;
    assign func_pulse = pulse_r;

    // ------------------------------------------------------------
    // power step repeat
    // ------------------------------------------------------------
    // lowest-index active power input wins
    always_comb begin
        pw_any = 1'b0;
        pw_is_inc = 1'b0;
        pw_idx = 4'h0;
        for (int i = RIOC_NUM_IN - 1; i >= 0; i--) begin
            if (inc_req[i] || dec_req[i]) begin
                pw_any = 1'b1;
                pw_is_inc = inc_req[i];
                pw_idx = 4'(i);
            end
        end
    end

    // first step at once, then one step per repeat interval
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pw_state_r <= RIOC_PW_IDLE;
            pw_cnt_r <= 32'h0000_0000;
            pw_step_r <= 1'b0;
            pw_inc_r <= 1'b0;
            pw_dec_r <= 1'b0;
            pw_idx_r <= 4'h0;
        end else begin
            pw_step_r <= 1'b0;
            pw_inc_r <= pw_any & pw_is_inc;
            pw_dec_r <= pw_any & ~pw_is_inc;
            pw_idx_r <= pw_idx;
            case (pw_state_r)
                RIOC_PW_IDLE: begin
                    if (pw_any) begin
                        pw_step_r <= 1'b1;
                        pw_cnt_r <= 32'h0000_0000;
                        pw_state_r <= RIOC_PW_HOLD;
                    end
                end
                RIOC_PW_HOLD: begin
                    if (!pw_any) begin
                        pw_state_r <= RIOC_PW_IDLE;
                    end else if (pw_cnt_r == 32'(REPEAT_CYC - 1)) begin
                        pw_step_r <= 1'b1;
                        pw_cnt_r <= 32'h0000_0000;
                    end else begin
                        pw_cnt_r <= pw_cnt_r + 32'h0000_0001;
                    end
                end
                default: pw_state_r <= RIOC_PW_IDLE;
            endcase
        end
    end
    assign power_inc = pw_inc_r;
    assign power_dec = pw_dec_r;
    assign power_step = pw_step_r;

    // ------------------------------------------------------------
    // outputs: open collector, low drive asserts
    // ------------------------------------------------------------
    // condition per channel, polarity, then release when unassigned
    always_comb begin
        for (int j = 0; j < RIOC_NUM_OUT; j++) begin
            if (chan_r[j] == RIOC_CH_NONE) begin
                drive_low[j] = 1'b0;
            end else if (chan_r[j] == RIOC_CH_REMOTE) begin
                drive_low[j] = ren_r ^ pol_r[j];
            end else if (chan_r[j] < RIOC_CH_SRC0 + 5'(RIOC_SRC_W)) begin
                // presets, exciters, alarms, audio paths
                drive_low[j] = status_src[4'(chan_r[j] - RIOC_CH_SRC0)]
                    ^ pol_r[j];
            end else begin
                drive_low[j] = 1'b0;
            end
        end
    end

    // registered pin drive; value always low, enable does the work
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            remote_out_oe <= '0;
        end else begin
            remote_out_oe <= drive_low;
        end
    end
    assign remote_out_o = '0;

endmodule // rioc_top

// ---- testbench/rioc_properties.sv ----
/*
 * Port checker for rioc_top, bound into every instance of it.
 * Assumes one clock domain and the registered timing of the hand-over.
 */
`timescale 1ns/1ps
module rioc_properties
    import rioc_pkg::*;
#(
    parameter int REPEAT_CYC = RIOC_REPEAT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [RIOC_NUM_IN-1:0] remote_in,
    input wire logic [RIOC_SRC_W-1:0] status_src,
    input wire logic [RIOC_NUM_IN-1:0] func_active,
    input wire logic [RIOC_NUM_IN-1:0] func_pulse,
    input wire logic power_inc,
    input wire logic power_dec,
    input wire logic power_step,
    input wire logic [RIOC_NUM_OUT-1:0] remote_out_o,
    input wire logic [RIOC_NUM_OUT-1:0] remote_out_oe
);
    logic [2:0] wr_h;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // history of register writes that may move state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_h <= 3'h0;
        end else begin
            wr_h <= {wr_h[1:0], psel && penable && pwrite};
        end
    end
    // a pin moved three or four edges back
    sequence s_pin_moved;
        ($past(remote_in, 4) != $past(remote_in, 5)) ||
        ($past(remote_in, 3) != $past(remote_in, 4));
    endsequence
    // a pin moved, or a register was written lately
    sequence s_state_cause;
        ($past(remote_in, 4) != $past(remote_in, 5)) ||
        ($past(remote_in, 3) != $past(remote_in, 4)) || (wr_h != 3'h0);
    endsequence
    property p_pulse_short;
        (func_pulse != '0) |=> ((func_pulse & $past(func_pulse)) == '0);
    endproperty
    property p_pulse_cause;
        (func_pulse != '0) |-> s_pin_moved;
    endproperty
    property p_func_cause;
        $changed(func_active) |-> s_state_cause;
    endproperty
    property p_step_gap;
        power_step |=> (!power_step) [*8];
    endproperty
    property p_step_req;
        power_step |-> power_inc || power_dec || $past(power_inc || power_dec);
    endproperty
    property p_one_dir;
        !(power_inc && power_dec);
    endproperty
    property p_oe_cause;
        $changed(remote_out_oe) |->
            ($past(status_src) != $past(status_src, 2)) || (wr_h != 3'h0);
    endproperty
    property p_oc_value;
        remote_out_o == '0;
    endproperty
    a_pulse_short: assert property (p_pulse_short)
        else $error("function pulse longer than one cycle");
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("function pulse without a pin edge");
    a_func_cause: assert property (p_func_cause)
        else $error("function state moved without a cause");
    a_step_gap: assert property (p_step_gap)
        else $error("power steps too close together");
    a_step_req: assert property (p_step_req)
        else $error("power step without a request");
    a_one_dir: assert property (p_one_dir)
        else $error("increase and decrease requested together");
    a_oe_cause: assert property (p_oe_cause)
        else $error("output moved without a source change");
    a_oc_value: assert property (p_oc_value)
        else $error("open collector output drives high");
endmodule // rioc_properties

bind rioc_top rioc_properties #(.REPEAT_CYC(REPEAT_CYC)) rioc_properties_i (
    .clk_sys, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .remote_in, .status_src, .func_active, .func_pulse,
    .power_inc, .power_dec, .power_step, .remote_out_o, .remote_out_oe
);

// ---- testbench/rioc_site_unit.sv ----
/*
 * Site equipment model: drives remote contacts and status levels and
 * resolves the open-collector outputs against a pull-up.
 */
`timescale 1ns/1ps
module rioc_site_unit
    import rioc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [RIOC_NUM_IN-1:0] want_in,
    input wire logic [RIOC_SRC_W-1:0] want_src,
    input wire logic [RIOC_NUM_OUT-1:0] remote_out_o,
    input wire logic [RIOC_NUM_OUT-1:0] remote_out_oe,
    output logic [RIOC_NUM_IN-1:0] remote_in,
    output logic [RIOC_SRC_W-1:0] status_src,
    output logic [RIOC_NUM_OUT-1:0] pin_lvl
);
    // contacts idle open at time zero
    initial begin
        remote_in = '0;
        status_src = '0;
    end
    // contacts and status change only just after an edge
    always @(posedge clk_sys) begin
        remote_in <= want_in;
        status_src <= want_src;
    end
    // released lines read high through the pull-up
    assign pin_lvl = (remote_out_oe & remote_out_o) | ~remote_out_oe;
endmodule // rioc_site_unit

// ---- testbench/rioc_top_tb_top.sv ----
/*
 * Bench for rioc_top: APB tasks, an input mode table and output mapping.
 * Assumes the site unit model stands on the pins and status bus.
 */
`timescale 1ns/1ps
module rioc_top_tb_top
    import rioc_pkg::*;
;
    localparam int RC = 20;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic power_inc, power_dec, power_step;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [RIOC_NUM_IN-1:0] remote_in, func_active, func_pulse, want_in;
    logic [RIOC_SRC_W-1:0] status_src, want_src;
    logic [RIOC_NUM_OUT-1:0] remote_out_o, remote_out_oe, pin_lvl, ex;
    logic [7:0] tbl [1:12];
    int fail_count, num_checks, nsteps, npul, base;
    rioc_top #(.REPEAT_CYC(RC)) rioc_top_i (.clk_sys, .resetn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .remote_in, .status_src, .func_active, .func_pulse, .power_inc,
        .power_dec, .power_step, .remote_out_o, .remote_out_oe);
    rioc_site_unit rioc_site_unit_i (.clk_sys, .want_in, .want_src,
        .remote_out_o, .remote_out_oe, .remote_in, .status_src, .pin_lvl);
    // clock at 125 MHz
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // pulse and step monitors
    always @(posedge clk_sys) begin
        npul <= npul + int'(func_pulse[0]);
        nsteps <= nsteps + int'(power_step);
    end
    task automatic wcyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            err = pslverr;
            q = prdata;
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one mode row: clear, prime with a pre mode, then three pin flips
    task automatic run_mode(input int m);
        apb(1'b1, RIOC_IMODE_OFS, 32'h0);
        want_in[0] <= tbl[m][3];
        wcyc(8);
        apb(1'b1, RIOC_IMODE_OFS, 32'(tbl[m][7:4]));
        want_in[0] <= ~want_in[0];
        wcyc(8);
        apb(1'b1, RIOC_IMODE_OFS, 32'(m));
        base = npul;
        for (int s = 0; s < 3; s++) begin
            want_in[0] <= ~want_in[0];
            wcyc(8);
            chk("func", 32'(tbl[m][2-s]), (m < 9) ? func_active[0] :
                (m < 11) ? power_inc : power_dec);
            if (s == 0) chk("pulse", 32'(m < 3), npul - base);
        end
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end
    // main sequence
    initial begin
        tbl = '{8'h0f, 8'h07, 8'h28, 8'h10, 8'h06, 8'h0e,
                8'h0d, 8'h05, 8'h0d, 8'h05, 8'h0d, 8'h05};
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {want_in, want_src, npul, fail_count, num_checks, nsteps} = '0;
        wcyc(20);
        resetn <= 1'b1;
        apb(1'b0, RIOC_IMODE_OFS + 12'h024, 32'h0);
        chk("imode_rst", 32'(RIOC_IMODE_RST), q);
        apb(1'b0, RIOC_OCFG_OFS + 12'h03c, 32'h0);
        chk("ocfg_rst", 32'(RIOC_CHAN_RST), q);
        chk("oe_rst", 32'h0, remote_out_oe);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 32'h1, {q[30:0], err});
        apb(1'b1, RIOC_IMODE_OFS, 32'(RIOC_M_RISE_ON));
        want_in[0] <= 1'b1;
        wcyc(8);
        chk("ignored", 32'h0, func_active[0]);
        $display("reset and gating test done");
        apb(1'b1, RIOC_CTRL_OFS, 32'h1);
        for (int m = 1; m <= 12; m++) run_mode(m);
        $display("input mode table done");
        apb(1'b1, RIOC_IMODE_OFS, 32'(RIOC_M_HI_INC));
        apb(1'b1, RIOC_IMODE_OFS + 12'h004, 32'(RIOC_M_HI_DEC));
        want_in[1:0] <= 2'b11;
        wcyc(8);
        chk("inc_dec", 32'h2, {power_inc, power_dec});
        base = nsteps;
        wcyc(3 * RC);
        chk("steps", 32'h3, nsteps - base);
        want_in[1:0] <= 2'b00;
        $display("power request test done");
        for (int j = 0; j < 16; j++)
            apb(1'b1, RIOC_OCFG_OFS + 12'(4 * j), (j < 14) ?
                32'(RIOC_CH_SRC0) + j : (j == 14) ? 32'(RIOC_CH_REMOTE) : 0);
        for (int j = 0; j < 14; j++) begin
            want_src <= 16'h8000 | 16'(1 << j);
            ex = 16'h4000 | 16'(1 << j);
            wcyc(4);
            chk("oe_map", 32'(ex), remote_out_oe);
            chk("pin", {16'h0000, ~ex}, pin_lvl);
        end
        want_src <= '0;
        apb(1'b1, RIOC_OCFG_OFS + 12'h00c, 32'h105);
        wcyc(4);
        chk("oe_pol", 32'h4008, remote_out_oe);
        apb(1'b1, RIOC_CTRL_OFS, 32'h0);
        wcyc(4);
        chk("oe_ren", 32'h0008, remote_out_oe);
        $display("output mapping test done");
        apb(1'b1, RIOC_EXEMPT_OFS, 32'h1);
        want_in[0] <= 1'b1;
        wcyc(8);
        chk("exempt", 32'h1, func_active[0]);
        $display("exempt test done");
        conclude();
    end
endmodule // rioc_top_tb_top
